// >>> src/mc_cell_top.sv
// macrocell with i/o cell, buried node and apb configuration registers
// assumes pins and clock inputs are synchronous to clock; board resolves pin from oe
`timescale 1ns/1ps
`default_nettype none
`include "mc_consts.svh"
module mc_cell_top (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // array terms
    input wire logic sum_term,
    input wire logic node_term,
    input wire logic oe_term,
    input wire logic latch_en_n,
    input wire logic async_preset_term,
    input wire logic async_clear_term,
    // dedicated clocks
    input wire logic clock_input_zero,
    input wire logic clock_input_one,
    input wire logic clock_input_two,
    input wire logic clock_input_three,
    // pin
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    // feedback into array
    output logic io_feedback,
    output logic node_feedback
);
    logic rst_sync1_q;
    logic rst_sync2_q;
    logic rst_n;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync1_q <= 1'b0;
            rst_sync2_q <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
            rst_sync2_q <= rst_sync1_q;
        end
    end
    assign rst_n = rst_sync2_q;

    // configuration registers
    logic [31:0] out_cfg_q, out_cfg_d;
    logic [31:0] bur_cfg_q, bur_cfg_d;
    logic [31:0] io_cfg_q, io_cfg_d;
    logic [31:0] clk_cfg_q, clk_cfg_d;
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d;
    logic wr_go;
    logic rd_go;
    logic hit;

    mc_pkg::cell_cfg_t out_cfg;
    mc_pkg::cell_cfg_t bur_cfg;
    mc_pkg::io_cfg_t io_cfg;
    mc_pkg::clk_cfg_t clk_cfg;
    logic out_result;
    logic bur_result;
    logic tick;
    logic series_two;
    logic [31:0] status;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                v[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return v;
    endfunction

    always_comb begin
        hit = (paddr == `MC_OFS_OUT_CFG) || (paddr == `MC_OFS_BUR_CFG) ||
              (paddr == `MC_OFS_IO_CFG) || (paddr == `MC_OFS_STATUS) ||
              (paddr == `MC_OFS_CLK_CFG);
        wr_go = psel && penable && pwrite;
        rd_go = psel && !penable && !pwrite;
        out_cfg_d = out_cfg_q;
        bur_cfg_d = bur_cfg_q;
        io_cfg_d = io_cfg_q;
        clk_cfg_d = clk_cfg_q;
        rdata_d = rdata_q;
        err_d = err_q;
        if (psel && !penable) begin
            err_d = !hit;
        end
        if (wr_go) begin
            case (paddr)
                `MC_OFS_OUT_CFG: out_cfg_d = merge(out_cfg_q, pwdata, pstrb);
                `MC_OFS_BUR_CFG: bur_cfg_d = merge(bur_cfg_q, pwdata, pstrb);
                `MC_OFS_IO_CFG: io_cfg_d = merge(io_cfg_q, pwdata, pstrb);
                `MC_OFS_CLK_CFG: clk_cfg_d = merge(clk_cfg_q, pwdata, pstrb);
                default: out_cfg_d = out_cfg_q;
            endcase
        end
        if (rd_go) begin
            case (paddr)
                `MC_OFS_OUT_CFG: rdata_d = out_cfg_q;
                `MC_OFS_BUR_CFG: rdata_d = bur_cfg_q;
                `MC_OFS_IO_CFG: rdata_d = io_cfg_q;
                `MC_OFS_STATUS: rdata_d = status;
                `MC_OFS_CLK_CFG: rdata_d = clk_cfg_q;
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // reads load in setup, writes commit at the access edge so an aborted setup writes nothing
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_cfg_q <= `MC_CFG_RESET;
            bur_cfg_q <= `MC_CFG_RESET;
            io_cfg_q <= `MC_IO_RESET;
            clk_cfg_q <= `MC_CFG_RESET;
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else begin
            out_cfg_q <= out_cfg_d;
            bur_cfg_q <= bur_cfg_d;
            io_cfg_q <= io_cfg_d;
            clk_cfg_q <= clk_cfg_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && err_q;
    assign prdata = rdata_q;

    assign io_cfg = mc_pkg::io_cfg_t'(io_cfg_q[`MC_SERIES2_BIT:`MC_OESEL_LSB]);
    assign clk_cfg = mc_pkg::clk_cfg_t'(clk_cfg_q[`MC_FOURCK_BIT:`MC_CKSEL_LSB]);
    assign series_two = io_cfg.series_two;

    // buried node capturing a paired input never takes t form
    always_comb begin
        out_cfg = mc_pkg::cell_cfg_t'(out_cfg_q[`MC_CLREN_BIT:`MC_MODE_LSB]);
        bur_cfg = mc_pkg::cell_cfg_t'(bur_cfg_q[`MC_CLREN_BIT:`MC_MODE_LSB]);
        if (io_cfg.pairing) begin
            bur_cfg.t_type = 1'b0;
        end
    end

    mc_clock_pick u_clock_pick (
        .clock(clock),
        .rst_n(rst_n),
        .cfg(clk_cfg),
        .clock_inputs({clock_input_three, clock_input_two, clock_input_one, clock_input_zero}),
        .tick(tick)
    );

    // one global preset/clear pin_node_pairing shared by both cells
    mc_storage u_out_cell (
        .clock(clock),
        .rst_n(rst_n),
        .cfg(out_cfg),
        .latch_ok(series_two),
        .tick(tick),
        .latch_en_n(latch_en_n),
        .sum(sum_term),
        .set_line(async_preset_term),
        .clr_line(async_clear_term),
        .result(out_result)
    );

    // paired node samples the pin, otherwise its own array term
    mc_storage u_bur_cell (
        .clock(clock),
        .rst_n(rst_n),
        .cfg(bur_cfg),
        .latch_ok(series_two),
        .tick(tick),
        .latch_en_n(latch_en_n),
        .sum(io_cfg.pairing ? pin_in : node_term),
        .set_line(async_preset_term),
        .clr_line(async_clear_term),
        .result(bur_result)
    );

    always_comb begin
        // programmable polarity toward the pin
        pin_out = out_result ^ io_cfg.invert;
        // three-state choice
        case (io_cfg.oe_sel)
            mc_pkg::OE_ON: pin_oe = 1'b1;
            mc_pkg::OE_TERM: pin_oe = oe_term;
            mc_pkg::OE_OFF: pin_oe = 1'b0;
            default: pin_oe = 1'b0;
        endcase
        // comb output feeds back the pin paired or node in use: pin
        if (out_cfg.mode == mc_pkg::MODE_COMB || io_cfg.pairing || io_cfg.node_fn) begin
            io_feedback = pin_in;
        end else begin
            io_feedback = out_result;
        end
        // buried feedback only on second series
        node_feedback = series_two ? bur_result : 1'b0;
    end

    assign status = {26'h000_0000, tick, pin_in, pin_oe, bur_result, out_result, series_two};
endmodule
`default_nettype wire

// >>> src/mc_consts.svh
// macrocell and i/o cell constants: config field layouts, register offsets, reset values
// assumes inclusion by bare name from any design file; definitions only
`ifndef MC_CONSTS_SVH
`define MC_CONSTS_SVH

`define MC_OFS_OUT_CFG 12'h000
`define MC_OFS_BUR_CFG 12'h004
`define MC_OFS_IO_CFG 12'h008
`define MC_OFS_STATUS 12'h00c
`define MC_OFS_CLK_CFG 12'h010

// output/buried cell config word: [1:0] mode, [2] t type, [3] set en, [4] clr en
`define MC_MODE_LSB 0
`define MC_MODE_MSB 1
`define MC_TTYPE_BIT 2
`define MC_SETEN_BIT 3
`define MC_CLREN_BIT 4
// io config word: [1:0] oe select, [2] invert, [3] pairing, [4] node own function, [5] series two
`define MC_OESEL_LSB 0
`define MC_OESEL_MSB 1
`define MC_INV_BIT 2
`define MC_PIN_NODE_PAIRING_BIT 3
`define MC_NODEFN_BIT 4
`define MC_SERIES2_BIT 5
// clock config: [1:0] clock select, [2] explicit select, [3] four-clock variant
`define MC_CKSEL_LSB 0
`define MC_CKSEL_MSB 1
`define MC_CKEXPL_BIT 2
`define MC_FOURCK_BIT 3

`define MC_CFG_RESET 32'h0000_0000
`define MC_IO_RESET 32'h0000_0020
`define MC_DEF_CLK_TWO 2'h1
`define MC_DEF_CLK_FOUR 2'h3

`endif

// >>> src/mc_pkg.sv
// types shared by the macrocell files
// assumes mc_consts.svh is available alongside
package mc_pkg;
    typedef enum logic [1:0] {
        MODE_COMB = 2'h0,
        MODE_LATCH = 2'h1,
        MODE_REG = 2'h2
    } cell_mode_t;

    typedef enum logic [1:0] {
        OE_OFF = 2'h0,
        OE_ON = 2'h1,
        OE_TERM = 2'h2
    } oe_sel_t;

    typedef struct packed {
        logic clr_en;
        logic set_en;
        logic t_type;
        cell_mode_t mode;
    } cell_cfg_t;

    typedef struct packed {
        logic series_two;
        logic node_fn;
        logic pairing;
        logic invert;
        oe_sel_t oe_sel;
    } io_cfg_t;

    typedef struct packed {
        logic four_clk;
        logic explicit_sel;
        logic [1:0] clk_sel;
    } clk_cfg_t;
endpackage

// >>> src/mc_storage.sv
// one macrocell storage element: combinational, latch, d or t register
// assumes the tick is a one-cycle pulse on the selected clock input
`timescale 1ns/1ps
`default_nettype none
`include "mc_consts.svh"
module mc_storage (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // configuration
    input wire mc_pkg::cell_cfg_t cfg,
    input wire logic latch_ok,
    // data
    input wire logic tick,
    input wire logic latch_en_n,
    input wire logic sum,
    input wire logic set_line,
    input wire logic clr_line,
    output logic result
);
    logic state_q;
    logic state_d;

    always_comb begin
        state_d = state_q;
        case (cfg.mode)
            mc_pkg::MODE_REG: begin
                if (tick) begin
                    // t toggles on one, holds on zero; no type chosen means d
                    state_d = cfg.t_type ? (state_q ^ sum) : sum;
                end
            end
            mc_pkg::MODE_LATCH: begin
                // open while enable low first series emulates in combinational form
                if (!latch_en_n || !latch_ok) begin
                    state_d = sum;
                end
            end
            mc_pkg::MODE_COMB: state_d = sum;
            default: state_d = sum;
        endcase
        // reset priority over set, both act regardless of tick
        if (cfg.clr_en && clr_line) begin
            state_d = 1'b0;
        end else if (cfg.set_en && set_line) begin
            state_d = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    // comb and transparent latch pass straight through; asserted set/clr show at once
    always_comb begin
        if (cfg.clr_en && clr_line) begin
            result = 1'b0;
        end else if (cfg.set_en && set_line) begin
            result = 1'b1;
        end else if (cfg.mode == mc_pkg::MODE_COMB) begin
            result = sum;
        end else if (cfg.mode == mc_pkg::MODE_LATCH && (!latch_en_n || !latch_ok)) begin
            result = sum;
        end else begin
            result = state_q;
        end
    end
endmodule
`default_nettype wire

// >>> src/mc_clock_pick.sv
// selects one of four clock inputs and emits a tick on its rising edge
// assumes clock inputs are synchronous samples at the system clock
`timescale 1ns/1ps
`default_nettype none
`include "mc_consts.svh"
module mc_clock_pick (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // selection
    input wire mc_pkg::clk_cfg_t cfg,
    input wire logic [3:0] clock_inputs,
    // result
    output logic tick
);
    logic [1:0] pick;
    logic prev_q;
    logic prev_d;
    logic level;

    always_comb begin
        // no explicit choice uses the variant default clock
        if (cfg.explicit_sel) begin
            pick = cfg.four_clk ? cfg.clk_sel : {1'b0, cfg.clk_sel[0]};
        end else begin
            pick = cfg.four_clk ? `MC_DEF_CLK_FOUR : `MC_DEF_CLK_TWO;
        end
        level = clock_inputs[pick];
        prev_d = level;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end

    assign tick = level & ~prev_q;
endmodule
`default_nettype wire

// >>> dv/mc_cell_top_properties.sv
// checker for the macrocell top, shadowing config writes seen on apb
// assumes full-word writes with all byte lanes set
`timescale 1ns/1ps
`default_nettype none
`include "mc_consts.svh"
module mc_cell_top_properties (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // cell
    input wire logic sum_term,
    input wire logic oe_term,
    input wire logic async_preset_term,
    input wire logic async_clear_term,
    input wire logic clock_input_one,
    input wire logic pin_in,
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic io_feedback
);
    logic [4:0] out_q;
    logic [4:0] out_d;
    logic [5:0] io_q;
    logic [5:0] io_d;
    logic [3:0] ck_q;
    logic [3:0] ck_d;
    logic wr;
    logic inv;
    logic regm;
    logic quiet;
    assign wr = psel && penable && pwrite;
    assign inv = io_q[`MC_INV_BIT];
    assign regm = out_q[1:0] == 2'h2;
    assign quiet = !async_preset_term && !async_clear_term;
    always_comb begin
        out_d = out_q;
        io_d = io_q;
        ck_d = ck_q;
        if (wr && paddr == `MC_OFS_OUT_CFG) begin
            out_d = pwdata[4:0];
        end
        if (wr && paddr == `MC_OFS_IO_CFG) begin
            io_d = pwdata[5:0];
        end
        if (wr && paddr == `MC_OFS_CLK_CFG) begin
            ck_d = pwdata[3:0];
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            out_q <= 5'h00;
            io_q <= 6'(`MC_IO_RESET);
            ck_q <= 4'h0;
        end else begin
            out_q <= out_d;
            io_q <= io_d;
            ck_q <= ck_d;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    property p_oe_off;
        io_q[1:0] == 2'h0 |-> !pin_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("driver on while off");
    property p_oe_term;
        io_q[1] |-> pin_oe == oe_term;
    endproperty
    a_oe_term: assert property (p_oe_term) else $error("driver ignores term");
    property p_clear;
        regm && out_q[4] && async_clear_term |-> pin_out == inv;
    endproperty
    a_clear: assert property (p_clear) else $error("clear not at once");
    property p_set;
        regm && out_q[3] && async_preset_term && !(async_clear_term && out_q[4])
            |-> pin_out == !inv;
    endproperty
    a_set: assert property (p_set) else $error("preset not at once");
    property p_comb_out;
        out_q[1:0] == 2'h0 && quiet |-> pin_out == (sum_term ^ inv);
    endproperty
    a_comb_out: assert property (p_comb_out) else $error("comb pin wrong");
    property p_comb_fb;
        out_q[1:0] == 2'h0 |-> io_feedback == pin_in;
    endproperty
    a_comb_fb: assert property (p_comb_fb) else $error("comb feedback wrong");
    property p_reg_fb;
        regm && !io_q[3] && !io_q[4] && quiet |-> io_feedback == (pin_out ^ inv);
    endproperty
    a_reg_fb: assert property (p_reg_fb) else $error("storage feedback wrong");
    property p_pin_node_pairing_fb;
        io_q[3] |-> io_feedback == pin_in;
    endproperty
    a_pin_node_pairing_fb: assert property (p_pin_node_pairing_fb) else $error("paired feedback wrong");
    property p_dreg;
        regm && !out_q[2] && ck_q == 4'h0 && $rose(clock_input_one) && quiet
            |=> pin_out == ($past(sum_term) ^ inv);
    endproperty
    a_dreg: assert property (p_dreg) else $error("d register wrong");
endmodule
`default_nettype wire

// >>> dv/mc_board_model.sv
// board side of the pin: resolves the wire from cell and board drivers
// assumes the board only drives while the cell driver is off
`timescale 1ns/1ps
`default_nettype none
module mc_board_model (
    // clock
    input wire logic clock,
    // cell side
    input wire logic pin_out,
    input wire logic pin_oe,
    // board side
    input wire logic board_en,
    input wire logic board_val,
    output logic pin_in
);
    // no pull on the pin: a released wire shows the inverse of its last driven level,
    // so a cell that trusts a floating pin reads the wrong value
    logic last_q = 1'b0;
    always @(posedge clock) begin
        if (pin_oe || board_en) begin
            last_q <= pin_in;
        end
    end
    always_comb begin
        if (pin_oe) begin
            pin_in = pin_out;
        end else if (board_en) begin
            pin_in = board_val;
        end else begin
            pin_in = !last_q;
        end
    end
endmodule
`default_nettype wire

// >>> dv/mc_cell_top_bench.sv
// self-checking bench for the macrocell top over apb
// assumes zero-wait apb and the board model on the pin
`timescale 1ns/1ps
`default_nettype none
`include "mc_consts.svh"
module mc_cell_top_bench;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sum_term = 1'b0;
    logic node_term = 1'b0;
    logic oe_term = 1'b0;
    logic latch_en_n = 1'b1;
    logic pre = 1'b0;
    logic clr = 1'b0;
    logic [3:0] ck = 4'h0;
    logic board_en = 1'b0;
    logic board_val = 1'b0;
    logic pin_in;
    logic pin_out;
    logic pin_oe;
    logic io_fb;
    logic node_fb;
    logic [31:0] rdat;
    logic rerr;
    int mismatches = 0;
    int num_checks = 0;
    always #2.5 clock = !clock;
    mc_cell_top mc_cell_top_i (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sum_term(sum_term), .node_term(node_term),
        .oe_term(oe_term), .latch_en_n(latch_en_n), .async_preset_term(pre),
        .async_clear_term(clr), .clock_input_zero(ck[0]), .clock_input_one(ck[1]),
        .clock_input_two(ck[2]), .clock_input_three(ck[3]), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .io_feedback(io_fb), .node_feedback(node_fb));
    mc_board_model mc_board_model_i (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
        .board_en(board_en), .board_val(board_val), .pin_in(pin_in));
    task automatic finish_test();
        if (mismatches == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            finish_test();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
        chk(rerr, err);
    endtask
    // one rising edge on a clock input with the sum term set up alongside
    task automatic pulse(input int i, input logic s);
        @(posedge clock);
        ck[i] <= 1'b1;
        sum_term <= s;
        @(posedge clock);
        ck[i] <= 1'b0;
        @(posedge clock);
        #1;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        rdchk(`MC_OFS_OUT_CFG, `MC_CFG_RESET, 1'b0);
        rdchk(`MC_OFS_BUR_CFG, `MC_CFG_RESET, 1'b0);
        rdchk(`MC_OFS_IO_CFG, `MC_IO_RESET, 1'b0);
        rdchk(`MC_OFS_CLK_CFG, 32'h0, 1'b0);
        rdchk(12'h020, 32'h0, 1'b1);
        apb(1'b1, `MC_OFS_IO_CFG, 32'h21);
        @(posedge clock);
        sum_term <= 1'b1;
        #1;
        chk(pin_out, 1'b1);
        chk(io_fb, 1'b1);
        apb(1'b1, `MC_OFS_IO_CFG, 32'h25);
        chk(pin_out, 1'b0);
        apb(1'b1, `MC_OFS_IO_CFG, 32'h22);
        for (int v = 0; v < 2; v++) begin
            @(posedge clock);
            oe_term <= v[0];
            #1;
            chk(pin_oe, v[0]);
        end
        apb(1'b1, `MC_OFS_IO_CFG, 32'h20);
        chk(pin_oe, 1'b0);
        apb(1'b1, `MC_OFS_IO_CFG, 32'h21);
        apb(1'b1, `MC_OFS_OUT_CFG, 32'h01);
        @(posedge clock);
        latch_en_n <= 1'b0;
        #1;
        chk(pin_out, 1'b1);
        @(posedge clock);
        latch_en_n <= 1'b1;
        @(posedge clock);
        sum_term <= 1'b0;
        #1;
        chk(pin_out, 1'b1);
        apb(1'b1, `MC_OFS_IO_CFG, 32'h01);
        chk(pin_out, 1'b0);
        apb(1'b1, `MC_OFS_IO_CFG, 32'h21);
        apb(1'b1, `MC_OFS_OUT_CFG, 32'h02);
        pulse(1, 1'b1);
        chk(pin_out, 1'b1);
        apb(1'b1, `MC_OFS_IO_CFG, 32'h25);
        chk(io_fb, 1'b1);
        apb(1'b1, `MC_OFS_IO_CFG, 32'h35);
        chk(io_fb, 1'b0);
        apb(1'b1, `MC_OFS_IO_CFG, 32'h21);
        pulse(0, 1'b0);
        chk(pin_out, 1'b1);
        apb(1'b1, `MC_OFS_CLK_CFG, 32'h4);
        pulse(0, 1'b0);
        chk(pin_out, 1'b0);
        apb(1'b1, `MC_OFS_CLK_CFG, 32'h8);
        pulse(1, 1'b1);
        chk(pin_out, 1'b0);
        pulse(3, 1'b1);
        chk(pin_out, 1'b1);
        apb(1'b1, `MC_OFS_CLK_CFG, 32'h0);
        apb(1'b1, `MC_OFS_OUT_CFG, 32'h06);
        pulse(1, 1'b1);
        chk(pin_out, 1'b0);
        pulse(1, 1'b0);
        chk(pin_out, 1'b0);
        pulse(1, 1'b1);
        chk(pin_out, 1'b1);
        apb(1'b1, `MC_OFS_OUT_CFG, 32'h1a);
        @(posedge clock);
        clr <= 1'b1;
        #1;
        chk(pin_out, 1'b0);
        @(posedge clock);
        clr <= 1'b0;
        pre <= 1'b1;
        #1;
        chk(pin_out, 1'b1);
        @(posedge clock);
        clr <= 1'b1;
        #1;
        chk(pin_out, 1'b0);
        @(posedge clock);
        pre <= 1'b0;
        clr <= 1'b0;
        apb(1'b1, `MC_OFS_OUT_CFG, 32'h12);
        @(posedge clock);
        pre <= 1'b1;
        #1;
        chk(pin_out, 1'b0);
        @(posedge clock);
        pre <= 1'b0;
        apb(1'b1, `MC_OFS_BUR_CFG, 32'h02);
        apb(1'b1, `MC_OFS_IO_CFG, 32'h20);
        @(posedge clock);
        node_term <= 1'b1;
        pulse(1, 1'b0);
        chk(node_fb, 1'b1);
        @(posedge clock);
        node_term <= 1'b0;
        board_en <= 1'b1;
        board_val <= 1'b1;
        apb(1'b1, `MC_OFS_IO_CFG, 32'h28);
        pulse(1, 1'b0);
        chk(node_fb, 1'b1);
        chk(io_fb, 1'b1);
        apb(1'b1, `MC_OFS_BUR_CFG, 32'h06);
        pulse(1, 1'b0);
        chk(node_fb, 1'b1);
        apb(1'b1, `MC_OFS_BUR_CFG, 32'h01);
        @(posedge clock);
        latch_en_n <= 1'b0;
        board_val <= 1'b0;
        #1;
        chk(node_fb, 1'b0);
        @(posedge clock);
        board_val <= 1'b1;
        #1;
        chk(node_fb, 1'b1);
        apb(1'b1, `MC_OFS_IO_CFG, 32'h08);
        chk(node_fb, 1'b0);
        rdchk(`MC_OFS_STATUS, 32'h14, 1'b0);
        finish_test();
    end
endmodule
bind mc_cell_top mc_cell_top_properties mc_cell_top_properties_i (.clock(clock),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .sum_term(sum_term), .oe_term(oe_term),
    .async_preset_term(async_preset_term), .async_clear_term(async_clear_term),
    .clock_input_one(clock_input_one), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .io_feedback(io_feedback));
`default_nettype wire
